// ===== verilog/tmw_pkg.sv
// constants shared by the waveform / one-shot timer
// assumes an AXI4-Lite master with 32-bit data and 8-bit byte addresses
// Overview of operation
// - waveform mode toggles output each underflow, primary then secondary, primary first
// - one-shot control register does nothing in waveform mode
// - count source is f1, f2, f8 or companion timer underflow
// - periods last (prescale+1)*(primary+1) or (prescale+1)*(secondary+1) ticks
// - writing run bit 1 starts waveform counting, 0 stops it
// - force halt bit 1 stops counting at once in either mode
// - waveform interrupt request comes with output change after secondary underflow
// - primary and prescale reads return live count, also during secondary
// - writes while stopped load reload and counter, while counting reload only
// - waveform updates take effect from primary period after primary write
// - output level select sets period levels or one-shot pulse polarity
// - output source select timer or port latch, latched at start or interrupt
// - one-shot gives one primary-length pulse per trigger, secondary unused
// - with run set, one-shot starts on go bit write or pin trigger
// - one-shot underflow reloads counter, ends pulse, clears active flag
// - any one-shot stop reloads the counter before rest
// - one-shot stopped by halt bit, run bit 0 or force halt
// - one-shot interrupt request comes as the pulse ends
// - pin trigger enable makes external pin the one-shot trigger
// - one-shot writes during counting shape the following pulse
// - active flag sets within one or two ticks, retriggers ignored
package tmw_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_OSC = 8'h04;
	localparam logic [7:0] OFF_IO = 8'h08;
	localparam logic [7:0] OFF_MODE = 8'h0C;
	localparam logic [7:0] OFF_PRE = 8'h10;
	localparam logic [7:0] OFF_PRI = 8'h14;
	localparam logic [7:0] OFF_SEC = 8'h18;
	localparam logic [7:0] OFF_ROUTE = 8'h1C;
	localparam logic [7:0] OFF_PORT = 8'h20;
	// timer_ctrl_reg fields
	localparam int RUN_BIT = 0;
	localparam int BUSY_BIT = 1;
	localparam int HALT_BIT = 2;
	// oneshot_ctrl_reg fields
	localparam int GO_BIT = 0;
	localparam int OS_HALT_BIT = 1;
	localparam int ACTIVE_BIT = 2;
	// timer_io_ctrl_reg fields
	localparam int LVL_BIT = 0;
	localparam int OSRC_BIT = 1;
	localparam int TRG_EN_BIT = 2;
	localparam int TRG_RISE_BIT = 3;
	// mode, route and port register fields
	localparam int MODE_BIT = 0;
	localparam int SRC_LO = 2;
	localparam int ROUTE_BIT = 0;
	localparam int PORT_BIT = 0;
	// count source codes
	localparam logic [1:0] SRC_F1 = 2'h0;
	localparam logic [1:0] SRC_F2 = 2'h1;
	localparam logic [1:0] SRC_F8 = 2'h2;
	localparam logic [1:0] SRC_COMP = 2'h3;
	// reset value and f8 divider terminal count
	localparam logic [7:0] RST_CNT = 8'hFF;
	localparam logic [2:0] DIV_F8 = 3'h7;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== verilog/tmw_timer.sv
// prescaled down-counting timer: waveform and one-shot modes
// assumes companion_uflow is a one-cycle pulse on ref_clk, pin async
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tmw_timer #(
	parameter int CNT_W = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// count source and pins
	input wire logic companion_uflow,
	input wire logic ext_trigger_pin,
	output logic pulse_out_pin,
	output logic pulse_out_en_b,
	output logic timer_irq
);
	generate
		if (CNT_W < 2 || CNT_W > 8) begin : g_bad_width
			$error("CNT_W must lie in 2..8");
		end
	endgenerate

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAVE = 4'h2,
		ST_ARM = 4'h4,
		ST_SHOT = 4'h8
	} tmw_state_t;

	function automatic logic is_mapped(input logic [7:0] a);
		return a == tmw_pkg::OFF_CTRL || a == tmw_pkg::OFF_OSC ||
			a == tmw_pkg::OFF_IO || a == tmw_pkg::OFF_MODE ||
			a == tmw_pkg::OFF_PRE || a == tmw_pkg::OFF_PRI ||
			a == tmw_pkg::OFF_SEC || a == tmw_pkg::OFF_ROUTE ||
			a == tmw_pkg::OFF_PORT;
	endfunction

	// bus holding registers
	logic aw_have;
	logic w_have;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic w_lane0;
	// control bits
	logic run;
	logic mode_os;
	logic [1:0] src_sel;
	logic lvl_sel;
	logic osrc_sel;
	logic trg_en;
	logic trg_rise;
	logic route_en;
	logic port_latch;
	// counters and reloads
	logic [CNT_W-1:0] pre_rld;
	logic [CNT_W-1:0] pri_rld;
	logic [CNT_W-1:0] sec_rld;
	logic [CNT_W-1:0] pri_use;
	logic [CNT_W-1:0] sec_use;
	logic [CNT_W-1:0] pre_cnt;
	logic [CNT_W-1:0] main_cnt;
	logic in_sec;
	logic pend;
	logic osrc_act;
	logic irq_pre;
	logic [2:0] div;
	logic [2:0] sy;
	logic trg_lvl;
	tmw_state_t state;
	tmw_state_t next_state;

	// write decode
	wire wr_go = aw_have & w_have & ~s_axi_bvalid;
	wire wr_ok = wr_go & w_lane0;
	wire wr_ctrl = wr_ok & (aw_addr == tmw_pkg::OFF_CTRL);
	wire wr_osc = wr_ok & (aw_addr == tmw_pkg::OFF_OSC);
	wire wr_io = wr_ok & (aw_addr == tmw_pkg::OFF_IO);
	wire wr_mode = wr_ok & (aw_addr == tmw_pkg::OFF_MODE);
	wire wr_pre = wr_ok & (aw_addr == tmw_pkg::OFF_PRE);
	wire wr_pri = wr_ok & (aw_addr == tmw_pkg::OFF_PRI);
	wire wr_sec = wr_ok & (aw_addr == tmw_pkg::OFF_SEC);
	wire wr_route = wr_ok & (aw_addr == tmw_pkg::OFF_ROUTE);
	wire wr_port = wr_ok & (aw_addr == tmw_pkg::OFF_PORT);
	wire [CNT_W-1:0] wd = w_data[CNT_W-1:0];

	// start and stop requests
	wire force_halt = wr_ctrl & w_data[tmw_pkg::HALT_BIT];
	wire next_run = force_halt ? 1'b0 :
		(wr_ctrl ? w_data[tmw_pkg::RUN_BIT] : run);
	wire os_go = wr_osc & mode_os & w_data[tmw_pkg::GO_BIT];
	wire os_halt = wr_osc & mode_os &
		w_data[tmw_pkg::OS_HALT_BIT];

	// trigger pin: change counts once the last two stages agree
	wire sy_agree = sy[1] == sy[2];
	wire trg_edge = sy_agree & (sy[2] != trg_lvl) & (sy[2] == trg_rise);
	wire pin_trig = trg_en & trg_edge;
	wire trig = mode_os & next_run & (os_go | pin_trig);

	// count source select
	wire tick = (src_sel == tmw_pkg::SRC_F1) ? 1'b1 :
		(src_sel == tmw_pkg::SRC_F2) ? div[0] :
		(src_sel == tmw_pkg::SRC_F8) ? (div == tmw_pkg::DIV_F8) :
		companion_uflow;

	// counting and underflow
	wire st_idle = state == ST_IDLE;
	wire st_wave = state == ST_WAVE;
	wire st_shot = state == ST_SHOT;
	wire counting = st_wave | st_shot;
	wire stopped = st_idle | (state == ST_ARM);
	wire pre_uf = tick & counting & (pre_cnt == '0);
	wire main_uf = pre_uf & (main_cnt == '0);
	wire sec_uf = main_uf & in_sec & st_wave;
	wire shot_uf = main_uf & st_shot;
	wire to_idle = ~st_idle & (next_state == ST_IDLE);
	wire starting = st_idle & (next_state != ST_IDLE);
	wire [CNT_W-1:0] next_pri = pend ? pri_rld : pri_use;
	wire tmr_raw = (st_wave & ~in_sec) | st_shot;
	wire tmr_pin = tmr_raw ^ lvl_sel;

	// read words
	logic [31:0] rd_val;
	always_comb begin
		rd_val = '0;
		case (s_axi_araddr)
			tmw_pkg::OFF_CTRL: begin
				rd_val[tmw_pkg::RUN_BIT] = run;
				rd_val[tmw_pkg::BUSY_BIT] = counting;
			end
			tmw_pkg::OFF_OSC: begin
				rd_val[tmw_pkg::ACTIVE_BIT] = st_shot;
			end
			tmw_pkg::OFF_IO: begin
				rd_val[tmw_pkg::LVL_BIT] = lvl_sel;
				rd_val[tmw_pkg::OSRC_BIT] = osrc_sel;
				rd_val[tmw_pkg::TRG_EN_BIT] = trg_en;
				rd_val[tmw_pkg::TRG_RISE_BIT] = trg_rise;
			end
			tmw_pkg::OFF_MODE: begin
				rd_val[tmw_pkg::MODE_BIT] = mode_os;
				rd_val[tmw_pkg::SRC_LO+1 -: 2] = src_sel;
			end
			tmw_pkg::OFF_PRE: rd_val[CNT_W-1:0] = pre_cnt;
			tmw_pkg::OFF_PRI: rd_val[CNT_W-1:0] = main_cnt;
			tmw_pkg::OFF_SEC: rd_val[CNT_W-1:0] = sec_rld;
			tmw_pkg::OFF_ROUTE: rd_val[tmw_pkg::ROUTE_BIT] = route_en;
			tmw_pkg::OFF_PORT: rd_val[tmw_pkg::PORT_BIT] = port_latch;
			default: rd_val = '0;
		endcase
	end

	// mode sequencer
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (next_run & ~mode_os) begin
					next_state = ST_WAVE;
				end else if (trig) begin
					next_state = ST_ARM;
				end
			end
			ST_WAVE: begin
				if (~next_run) begin
					next_state = ST_IDLE;
				end
			end
			ST_ARM: begin
				if (~next_run | os_halt) begin
					next_state = ST_IDLE;
				end else if (tick) begin
					next_state = ST_SHOT;
				end
			end
			ST_SHOT: begin
				if (~next_run | os_halt | shot_uf) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// bus channels
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tmw_pkg::RESP_OKAY;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_lane0 <= 1'b0;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_have <= 1'b1;
				w_data <= s_axi_wdata;
				w_lane0 <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(aw_addr) ?
					tmw_pkg::RESP_OKAY : tmw_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= tmw_pkg::RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= is_mapped(s_axi_araddr) ?
				tmw_pkg::RESP_OKAY : tmw_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// control registers
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			run <= 1'b0;
			mode_os <= 1'b0;
			src_sel <= tmw_pkg::SRC_F1;
			lvl_sel <= 1'b0;
			osrc_sel <= 1'b0;
			trg_en <= 1'b0;
			trg_rise <= 1'b0;
			route_en <= 1'b0;
			port_latch <= 1'b0;
		end else begin
			run <= next_run;
			if (wr_mode) begin
				mode_os <= w_data[tmw_pkg::MODE_BIT];
				src_sel <= w_data[tmw_pkg::SRC_LO+1 -: 2];
			end
			if (wr_io) begin
				lvl_sel <= w_data[tmw_pkg::LVL_BIT];
				osrc_sel <= w_data[tmw_pkg::OSRC_BIT];
				trg_en <= w_data[tmw_pkg::TRG_EN_BIT];
				trg_rise <= w_data[tmw_pkg::TRG_RISE_BIT];
			end
			if (wr_route) begin
				route_en <= w_data[tmw_pkg::ROUTE_BIT];
			end
			if (wr_port) begin
				port_latch <= w_data[tmw_pkg::PORT_BIT];
			end
		end
	end

	// reload registers
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pre_rld <= tmw_pkg::RST_CNT[CNT_W-1:0];
			pri_rld <= tmw_pkg::RST_CNT[CNT_W-1:0];
			sec_rld <= tmw_pkg::RST_CNT[CNT_W-1:0];
		end else begin
			if (wr_pre) begin
				pre_rld <= wd;
			end
			if (wr_pri) begin
				pri_rld <= wd;
			end
			if (wr_sec) begin
				sec_rld <= wd;
			end
		end
	end

	// counters
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pre_cnt <= tmw_pkg::RST_CNT[CNT_W-1:0];
			main_cnt <= tmw_pkg::RST_CNT[CNT_W-1:0];
			pri_use <= tmw_pkg::RST_CNT[CNT_W-1:0];
			sec_use <= tmw_pkg::RST_CNT[CNT_W-1:0];
			in_sec <= 1'b0;
			pend <= 1'b0;
		end else if (to_idle) begin
			pre_cnt <= pre_rld;
			main_cnt <= pri_rld;
			pri_use <= pri_rld;
			sec_use <= sec_rld;
			in_sec <= 1'b0;
			pend <= 1'b0;
		end else if (stopped) begin
			in_sec <= 1'b0;
			if (wr_pre) begin
				pre_cnt <= wd;
			end
			if (wr_pri) begin
				main_cnt <= wd;
				pri_use <= wd;
			end
			if (wr_sec) begin
				sec_use <= wd;
			end
		end else begin
			if (wr_pri) begin
				pend <= 1'b1;
			end
			if (pre_uf) begin
				pre_cnt <= pre_rld;
				if (main_cnt != '0) begin
					main_cnt <= main_cnt - 1'b1;
				end else if (in_sec) begin
					in_sec <= 1'b0;
					main_cnt <= next_pri;
					if (pend) begin
						pri_use <= pri_rld;
						sec_use <= sec_rld;
						pend <= wr_pri;
					end
				end else if (st_wave) begin
					in_sec <= 1'b1;
					main_cnt <= sec_use;
				end
			end else if (tick) begin
				pre_cnt <= pre_cnt - 1'b1;
			end
		end
	end

	// state, source divider and trigger synchroniser
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			div <= '0;
			sy <= '0;
			trg_lvl <= 1'b0;
		end else begin
			state <= next_state;
			div <= div + 1'b1;
			sy <= {sy[1:0], ext_trigger_pin};
			if (sy_agree) begin
				trg_lvl <= sy[2];
			end
		end
	end

	// pin and interrupt: both change on the same edge
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			irq_pre <= 1'b0;
			timer_irq <= 1'b0;
			osrc_act <= 1'b0;
			pulse_out_pin <= 1'b0;
			pulse_out_en_b <= 1'b1;
		end else begin
			irq_pre <= sec_uf | shot_uf;
			timer_irq <= irq_pre;
			if (starting | irq_pre) begin
				osrc_act <= osrc_sel;
			end
			pulse_out_pin <= osrc_act ? port_latch : tmr_pin;
			pulse_out_en_b <= ~route_en;
		end
	end
endmodule // tmw_timer

// ===== tb/tmw_timer_props.sv
// assertions on the timer's bus and interrupt ports
// bound into every tmw_timer; sees its ports only
`timescale 1ns/1ps
module tmw_timer_props #(
	parameter int CNT_W = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins
	input wire logic companion_uflow,
	input wire logic ext_trigger_pin,
	input wire logic pulse_out_pin,
	input wire logic pulse_out_en_b,
	input wire logic timer_irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_aw_refuse:
	assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address ready right after take");
	chk_w_refuse:
	assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("write data ready right after take");
	chk_wr_answer:
	assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	chk_rd_answer:
	assert property (s_rd_take |=> !s_axi_arready ##[0:1] s_axi_rvalid)
		else $error("read answer late");
	chk_b_hold:
	assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_r_hold:
	assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_slverr_zero:
	assert property (s_axi_rvalid && s_axi_rresp == tmw_pkg::RESP_SLVERR
		|-> s_axi_rdata == 32'h0)
		else $error("error read returned data");
	chk_irq_single:
	assert property (timer_irq |=> !timer_irq)
		else $error("interrupt request longer than one cycle");
endmodule // tmw_timer_props

bind tmw_timer tmw_timer_props #(.CNT_W(CNT_W)) u_props (.*);

// ===== tb/tmw_pin_model.sv
// bench model of the circuit on the timer's pins
// reports each level run of the driven pulse pin; drives the trigger pin
`timescale 1ns/1ps
module tmw_pin_model (
	// clock
	input wire logic ref_clk,
	// timer pins
	input wire logic pulse_out_pin,
	input wire logic pulse_out_en_b,
	output logic ext_trigger_pin,
	// bench side
	input wire logic meas_en,
	input wire logic fire,
	input wire logic [3:0] fire_dly,
	output logic run_done,
	output logic run_lvl,
	output logic [15:0] run_len
);
	logic seen, last;
	logic [15:0] cnt;
	initial begin
		{ext_trigger_pin, run_done, seen, last, cnt} = '0;
	end
	// the run before the first change began before measuring: not reported
	always @(posedge ref_clk) begin
		run_done <= 1'b0;
		last <= pulse_out_pin;
		if (!meas_en || pulse_out_en_b)
			seen <= 1'b0;
		else if (pulse_out_pin !== last) begin
			run_done <= seen;
			run_lvl <= last;
			run_len <= cnt;
			cnt <= 16'h1;
			seen <= 1'b1;
		end else
			cnt <= cnt + 16'h1;
	end
	// a slow answer comes fire_dly cycles after the request
	always @(posedge fire) begin
		repeat (fire_dly) @(posedge ref_clk);
		ext_trigger_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		ext_trigger_pin <= 1'b0;
	end
endmodule // tmw_pin_model

// ===== tb/testbench.sv
// self-checking bench for the waveform / one-shot timer
// assumes tmw_pin_model on the pins and tmw_timer_props bound in
`timescale 1ns/1ps
module testbench;
	logic ref_clk, rst_b, companion_uflow, ext_trigger_pin;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, e;
	logic [3:0] s_axi_wstrb, fire_dly;
	logic [1:0] s_axi_bresp, s_axi_rresp, cdiv;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, pulse_out_pin, pulse_out_en_b;
	logic timer_irq, meas_en, fire, run_done, run_lvl;
	logic [15:0] run_len;
	logic [31:0] rq[$], wq[$];
	int bad_count, check_count, irqs;
	int unsigned p, m, c, s, mult[4] = '{1, 2, 8, 3};
	tmw_timer i_dut (.*);
	tmw_pin_model i_pins (.*);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// companion underflow every third cycle
	always @(posedge ref_clk) begin
		cdiv <= (cdiv == 2'h2) ? 2'h0 : cdiv + 2'h1;
		companion_uflow <= (cdiv == 2'h2);
		if (timer_irq === 1'b1) irqs++;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want) begin
			bad_count++;
			$display("CHECK FAILED %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task automatic tick(inout int n);
		@(posedge ref_clk);
		n++;
		if (n > 20000) begin
			bad_count++;
			close_out();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = tmw_pkg::RESP_OKAY);
		int n;
		n = 0;
		rq.push_back({30'h0, r});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			tick(n);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] want,
		input logic [1:0] r = tmw_pkg::RESP_OKAY);
		int n;
		n = 0;
		rq.push_back(want);
		rq.push_back({30'h0, r});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			tick(n);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
	endtask
	task automatic drain(input int k);
		int n;
		n = 0;
		while (wq.size() > k) tick(n);
	endtask
	function automatic logic [31:0] run(input logic l, input int unsigned v);
		return {15'h0, l, 16'((p + 1) * (v + 1) * mult[s])};
	endfunction
	// oldest note against each answer; all ones marks a run not compared
	always @(posedge ref_clk) begin
		if (s_axi_bvalid && s_axi_bready)
			chk({30'h0, s_axi_bresp}, rq.pop_front());
		if (s_axi_rvalid && s_axi_rready) begin
			chk(s_axi_rdata, rq.pop_front());
			chk({30'h0, s_axi_rresp}, rq.pop_front());
		end
		if (run_done === 1'b1 && wq.size() != 0) begin
			e = wq.pop_front();
			if (e !== 32'hFFFFFFFF)
				chk({15'h0, run_lvl, run_len}, e);
		end
	end
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} = '0;
		{s_axi_wvalid, s_axi_arvalid, companion_uflow, cdiv, rst_b} = '0;
		{meas_en, fire, fire_dly} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = '1;
		void'($urandom(38));
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		for (s = 0; s < 3; s++)
			rd(tmw_pkg::OFF_PRE + 8'(4 * s), 32'hFF);
		rd(tmw_pkg::OFF_CTRL, 32'h0);
		rd(8'h24, 32'h0, tmw_pkg::RESP_SLVERR);
		wr(8'h24, 32'h1, tmw_pkg::RESP_SLVERR);
		$display("test reset done");
		wr(tmw_pkg::OFF_ROUTE, 32'h1);
		for (s = 0; s < 4; s++) begin
			p = $urandom_range(3);
			m = $urandom_range(7, 1);
			c = $urandom_range(7, 1);
			wr(tmw_pkg::OFF_MODE, s << tmw_pkg::SRC_LO);
			wr(tmw_pkg::OFF_IO, s & 1);
			wr(tmw_pkg::OFF_PRE, p);
			wr(tmw_pkg::OFF_PRI, m);
			wr(tmw_pkg::OFF_SEC, c);
			rd(tmw_pkg::OFF_PRI, m);
			wq = '{'1, run(s[0], c), run(~s[0], m), run(s[0], c)};
			irqs = 0;
			meas_en <= 1'b1;
			wr(tmw_pkg::OFF_CTRL, 32'h1);
			wr(tmw_pkg::OFF_OSC, 32'h1);
			drain(0);
			chk(irqs, 2);
			meas_en <= 1'b0;
			wr(tmw_pkg::OFF_CTRL, 32'h4);
			rd(tmw_pkg::OFF_CTRL, 32'h0);
		end
		$display("test waveform done");
		p = $urandom_range(3, 1);
		m = $urandom_range(15, 8);
		c = m + 3;
		s = 0;
		wr(tmw_pkg::OFF_MODE, 32'h1);
		wr(tmw_pkg::OFF_IO, 32'h0);
		wr(tmw_pkg::OFF_PRE, p);
		wr(tmw_pkg::OFF_PRI, m);
		wr(tmw_pkg::OFF_CTRL, 32'h1);
		irqs = 0;
		wq = '{run(1, m), '1, run(1, c)};
		meas_en <= 1'b1;
		wr(tmw_pkg::OFF_OSC, 32'h1);
		wr(tmw_pkg::OFF_OSC, 32'h1);
		wr(tmw_pkg::OFF_PRI, c);
		drain(2);
		rd(tmw_pkg::OFF_OSC, 32'h0);
		rd(tmw_pkg::OFF_PRI, c);
		chk(irqs, 1);
		wr(tmw_pkg::OFF_IO, 32'hC);
		fire_dly <= 4'($urandom_range(9));
		fire <= 1'b1;
		@(posedge ref_clk);
		fire <= 1'b0;
		drain(0);
		meas_en <= 1'b0;
		$display("test one-shot done");
		wr(tmw_pkg::OFF_PRI, 32'h40);
		for (s = 0; s < 3; s++) begin
			wr(tmw_pkg::OFF_CTRL, 32'h1);
			wr(tmw_pkg::OFF_OSC, 32'h1);
			wr(s == 0 ? tmw_pkg::OFF_OSC : tmw_pkg::OFF_CTRL,
				s == 0 ? 2 : 4 * s - 4);
			rd(tmw_pkg::OFF_OSC, 32'h0);
			rd(tmw_pkg::OFF_PRI, 32'h40);
		end
		// port latch on the pin, pin trigger disabled
		wr(tmw_pkg::OFF_IO, 32'h2);
		wr(tmw_pkg::OFF_CTRL, 32'h1);
		fire_dly <= 4'h0;
		fire <= 1'b1;
		@(posedge ref_clk);
		fire <= 1'b0;
		repeat (10) @(posedge ref_clk);
		rd(tmw_pkg::OFF_OSC, 32'h0);
		wr(tmw_pkg::OFF_OSC, 32'h1);
		rd(tmw_pkg::OFF_OSC, 32'h4);
		chk({31'h0, pulse_out_pin}, 32'h0);
		wr(tmw_pkg::OFF_CTRL, 32'h4);
		$display("test one-shot stop done");
		close_out();
	end
endmodule // testbench
